// File: verilog/sps_pkg.sv
package sps_pkg;

	localparam int FLAG_N  = 8;
	localparam int IDX_W   = 3;
	localparam int DATA_W  = 8;
	localparam int CLK_NS  = 8;
	// length of one pin phase; every access spans four phases
	localparam int T_STEP_NS = 20;
	localparam int STEP_CYC  = (T_STEP_NS + CLK_NS - 1) / CLK_NS;

	localparam logic FLAG_TAKEN = 1'b0;
	localparam logic FLAG_FREE  = 1'b1;

	localparam int AXI_AW = 8;
	localparam logic [AXI_AW-1:0] REG_CMD    = 8'h00;
	localparam logic [AXI_AW-1:0] REG_STATUS = 8'h04;
	localparam logic [AXI_AW-1:0] REG_OWNED  = 8'h08;

	localparam int CMD_IDX_LSB    = 0;
	localparam int CMD_OP_LSB     = 4;
	localparam int CMD_RETRY_BIT  = 8;
	localparam int CMD_CANCEL_BIT = 9;

	localparam int STS_BUSY_BIT  = 0;
	localparam int STS_DONE_BIT  = 1;
	localparam int STS_GRANT_BIT = 2;
	localparam int STS_IDX_LSB   = 8;
	localparam int STS_BYTE_LSB  = 16;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		OP_READ    = 2'b00,
		OP_ACQUIRE = 2'b01,
		OP_RELEASE = 2'b10,
		OP_INIT    = 2'b11
	} sps_op_t;

endpackage

// File: verilog/sps_acc_if.sv
`timescale 1ns/1ps
`default_nettype none
// one pin access requested by the command sequencer
interface sps_acc_if;
	import sps_pkg::*;
	logic              req;
	logic              wr;
	logic [IDX_W-1:0]  idx;
	logic              wbit;
	logic              done;
	logic [DATA_W-1:0] rdata;

	modport ctl (output req, output wr, output idx, output wbit,
		input done, input rdata);
	modport eng (input req, input wr, input idx, input wbit,
		output done, output rdata);
endinterface
`default_nettype wire

// File: verilog/sps_pin_engine.sv
`timescale 1ns/1ps
`default_nettype none
module sps_pin_engine
	import sps_pkg::*;
#(
	parameter int STEP = STEP_CYC
) (
	input  wire logic              clk_sys,
	input  wire logic              nrst,
	sps_acc_if.eng                 acc,
	output var  logic              ce_n,
	output var  logic              semaphore_select_n,
	output var  logic              oe_n,
	output var  logic              rw_n,
	output var  logic [IDX_W-1:0]  flag_index_lines,
	output var  logic [DATA_W-1:0] io_out,
	output var  logic              io_oe_n,
	input  wire logic [DATA_W-1:0] io_in
);

	typedef enum logic [2:0] {
		E_IDLE    = 3'b000,
		E_SETUP   = 3'b001,
		E_STROBE  = 3'b010,
		E_HOLD    = 3'b011,
		E_RECOVER = 3'b100
	} sps_eng_t;

	sps_eng_t          st_q;
	logic              wr_q;
	logic [7:0]        div_q;
	logic              tick;
	logic [DATA_W-1:0] sync1_q;
	logic [DATA_W-1:0] sync2_q;

	assign tick = (div_q == 8'(STEP - 1));

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			div_q <= 8'h00;
		end else if (st_q == E_IDLE || tick) begin
			div_q <= 8'h00;
		end else begin
			div_q <= div_q + 8'h01;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= io_in;
			sync2_q <= sync1_q;
		end
	end

	// the memory array is never selected from this port
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ce_n <= 1'b1;
		end else begin
			ce_n <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_q               <= E_IDLE;
			wr_q               <= 1'b0;
			semaphore_select_n <= 1'b1;
			oe_n               <= 1'b1;
			rw_n               <= 1'b1;
			flag_index_lines   <= '0;
			io_out             <= '0;
			io_oe_n            <= 1'b1;
			acc.done           <= 1'b0;
			acc.rdata          <= '0;
		end else begin
			acc.done <= 1'b0;
			unique case (st_q)
			E_IDLE: begin
				if (acc.req) begin
					wr_q               <= acc.wr;
					semaphore_select_n <= 1'b0;
					flag_index_lines   <= acc.idx;
					// value replicated; the device looks at bit zero only
					io_out             <= {DATA_W{acc.wbit}};
					io_oe_n            <= ~acc.wr;
					st_q               <= E_SETUP;
				end
			end
			E_SETUP: begin
				if (tick) begin
					if (wr_q) begin
						rw_n <= 1'b0;
					end else begin
						oe_n <= 1'b0;
					end
					st_q <= E_STROBE;
				end
			end
			E_STROBE: begin
				if (tick) begin
					st_q <= E_HOLD;
				end
			end
			E_HOLD: begin
				// two phases of strobe cover the input synchroniser delay
				if (tick) begin
					rw_n      <= 1'b1;
					oe_n      <= 1'b1;
					acc.rdata <= sync2_q;
					st_q      <= E_RECOVER;
				end
			end
			E_RECOVER: begin
				if (tick) begin
					semaphore_select_n <= 1'b1;
					io_oe_n            <= 1'b1;
					acc.done           <= 1'b1;
					st_q               <= E_IDLE;
				end
			end
			default: begin
				st_q <= E_IDLE;
			end
			endcase
		end
	end

endmodule // sps_pin_engine
`default_nettype wire

// File: verilog/sps_host.sv
`timescale 1ns/1ps
`default_nettype none
module sps_host
	import sps_pkg::*;
#(
	parameter int STEP = STEP_CYC
) (
	input  wire logic              clk_sys,
	input  wire logic              nrst,
	input  wire logic [AXI_AW-1:0] s_axi_awaddr,
	input  wire logic [2:0]        s_axi_awprot,
	input  wire logic              s_axi_awvalid,
	output var  logic              s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output var  logic              s_axi_wready,
	output var  logic [1:0]        s_axi_bresp,
	output var  logic              s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [AXI_AW-1:0] s_axi_araddr,
	input  wire logic [2:0]        s_axi_arprot,
	input  wire logic              s_axi_arvalid,
	output var  logic              s_axi_arready,
	output var  logic [31:0]       s_axi_rdata,
	output var  logic [1:0]        s_axi_rresp,
	output var  logic              s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output var  logic              ce_n,
	output var  logic              semaphore_select_n,
	output var  logic              oe_n,
	output var  logic              rw_n,
	output var  logic [IDX_W-1:0]  flag_index_lines,
	output var  logic [DATA_W-1:0] io_out,
	output var  logic              io_oe_n,
	input  wire logic [DATA_W-1:0] io_in
);

	typedef enum logic [2:0] {
		C_IDLE    = 3'b000,
		C_ACQ_WR  = 3'b001,
		C_ACQ_RD  = 3'b010,
		C_REL_WR  = 3'b011,
		C_READ    = 3'b100,
		C_INIT_WR = 3'b101
	} sps_cmd_t;

	sps_acc_if acc ();

	sps_pin_engine #(
		.STEP (STEP)
	) u_eng (
		.clk_sys            (clk_sys),
		.nrst               (nrst),
		.acc                (acc.eng),
		.ce_n               (ce_n),
		.semaphore_select_n (semaphore_select_n),
		.oe_n               (oe_n),
		.rw_n               (rw_n),
		.flag_index_lines   (flag_index_lines),
		.io_out             (io_out),
		.io_oe_n            (io_oe_n),
		.io_in              (io_in)
	);

	logic              aw_got_q;
	logic              w_got_q;
	logic [AXI_AW-1:0] awaddr_q;
	logic [31:0]       wdata_q;
	logic [3:0]        wstrb_q;
	logic              go_q;
	logic              cancel_set;
	logic              cancel_q;
	logic [IDX_W-1:0]  cmd_idx_q;
	sps_op_t           cmd_op_q;
	logic              retry_q;
	sps_cmd_t          st_q;
	logic              pend_q;
	logic              busy_q;
	logic              done_q;
	logic              grant_q;
	logic [DATA_W-1:0] last_byte_q;
	logic [FLAG_N-1:0] owned_q;
	logic              finish;
	logic [31:0]       rd_word;
	logic              rd_ok;
	logic              wr_commit;

	// write address and data are taken independently, answered together
	assign wr_commit = aw_got_q && w_got_q && !s_axi_bvalid;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			aw_got_q      <= 1'b0;
			s_axi_awready <= 1'b0;
			awaddr_q      <= '0;
		end else if (s_axi_awready && s_axi_awvalid) begin
			aw_got_q      <= 1'b1;
			s_axi_awready <= 1'b0;
			awaddr_q      <= s_axi_awaddr;
		end else if (wr_commit) begin
			aw_got_q <= 1'b0;
		end else if (!aw_got_q && !s_axi_bvalid) begin
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			w_got_q      <= 1'b0;
			s_axi_wready <= 1'b0;
			wdata_q      <= '0;
			wstrb_q      <= '0;
		end else if (s_axi_wready && s_axi_wvalid) begin
			w_got_q      <= 1'b1;
			s_axi_wready <= 1'b0;
			wdata_q      <= s_axi_wdata;
			wstrb_q      <= s_axi_wstrb;
		end else if (wr_commit) begin
			w_got_q <= 1'b0;
		end else if (!w_got_q && !s_axi_bvalid) begin
			s_axi_wready <= 1'b1;
		end
	end

	// a command written while busy is dropped, the answer stays okay
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
			go_q         <= 1'b0;
			cmd_idx_q    <= '0;
			cmd_op_q     <= OP_READ;
			retry_q      <= 1'b0;
		end else begin
			go_q <= 1'b0;
			if (wr_commit) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= RESP_OKAY;
				if (awaddr_q == REG_CMD) begin
					if (wstrb_q[0] && !busy_q) begin
						go_q      <= 1'b1;
						cmd_idx_q <= wdata_q[CMD_IDX_LSB +: IDX_W];
						cmd_op_q  <= sps_op_t'(wdata_q[CMD_OP_LSB +: 2]);
						retry_q   <= wdata_q[CMD_RETRY_BIT];
					end
				end else if (awaddr_q != REG_STATUS &&
					awaddr_q != REG_OWNED) begin
					s_axi_bresp <= RESP_SLVERR;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	assign cancel_set = wr_commit && awaddr_q == REG_CMD &&
		wstrb_q[1] && wdata_q[CMD_CANCEL_BIT] && busy_q;

	// a cancel arriving as the command ends still wins over the clear
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cancel_q <= 1'b0;
		end else if (cancel_set) begin
			cancel_q <= 1'b1;
		end else if (finish) begin
			cancel_q <= 1'b0;
		end
	end

	always_comb begin
		rd_ok   = 1'b1;
		rd_word = '0;
		unique case (s_axi_araddr)
		REG_CMD: begin
			rd_word[CMD_IDX_LSB +: IDX_W] = cmd_idx_q;
			rd_word[CMD_OP_LSB +: 2]      = cmd_op_q;
			rd_word[CMD_RETRY_BIT]        = retry_q;
		end
		REG_STATUS: begin
			rd_word[STS_BUSY_BIT]            = busy_q;
			rd_word[STS_DONE_BIT]            = done_q;
			rd_word[STS_GRANT_BIT]           = grant_q;
			rd_word[STS_IDX_LSB +: IDX_W]    = cmd_idx_q;
			rd_word[STS_BYTE_LSB +: DATA_W]  = last_byte_q;
		end
		REG_OWNED: begin
			rd_word[FLAG_N-1:0] = owned_q;
		end
		default: begin
			rd_ok = 1'b0;
		end
		endcase
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arready && s_axi_arvalid) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_word;
			s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end else if (!s_axi_rvalid) begin
			s_axi_arready <= 1'b1;
		end
	end

	logic flag_rd;
	// every data bit carries the flag; bit zero is enough
	assign flag_rd = acc.rdata[0];
	assign finish  = acc.done && (
		(st_q == C_ACQ_RD && (flag_rd == FLAG_TAKEN ||
			(retry_q && !cancel_q) ? flag_rd == FLAG_TAKEN : 1'b0)) ||
		st_q == C_REL_WR || st_q == C_READ ||
		(st_q == C_INIT_WR && acc.idx == IDX_W'(FLAG_N - 1)));

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_q     <= C_IDLE;
			pend_q   <= 1'b0;
			acc.req  <= 1'b0;
			acc.wr   <= 1'b0;
			acc.wbit <= FLAG_FREE;
			acc.idx  <= '0;
		end else begin
			acc.req <= 1'b0;
			if (st_q != C_IDLE && !pend_q) begin
				pend_q   <= 1'b1;
				acc.req  <= 1'b1;
				acc.idx  <= (st_q == C_INIT_WR) ? acc.idx : cmd_idx_q;
				acc.wr   <= (st_q != C_ACQ_RD && st_q != C_READ);
				acc.wbit <= (st_q == C_ACQ_WR) ? FLAG_TAKEN : FLAG_FREE;
			end
			if (acc.done) begin
				pend_q <= 1'b0;
			end
			unique case (st_q)
			C_IDLE: begin
				if (go_q) begin
					unique case (cmd_op_q)
					OP_READ:    st_q <= C_READ;
					OP_ACQUIRE: st_q <= C_ACQ_WR;
					OP_RELEASE: st_q <= C_REL_WR;
					OP_INIT: begin
						st_q    <= C_INIT_WR;
						acc.idx <= '0;
					end
					endcase
				end
			end
			C_ACQ_WR: begin
				if (acc.done) begin
					st_q <= C_ACQ_RD;
				end
			end
			C_ACQ_RD: begin
				// a pending request reads one; poll or withdraw, never leave it
				if (acc.done && flag_rd == FLAG_TAKEN) begin
					st_q <= C_IDLE;
				end else if (acc.done && !(retry_q && !cancel_q)) begin
					st_q <= C_REL_WR;
				end else if (acc.done) begin
					st_q <= C_ACQ_RD;
				end
			end
			C_REL_WR, C_READ: begin
				if (acc.done) begin
					st_q <= C_IDLE;
				end
			end
			C_INIT_WR: begin
				if (acc.done) begin
					if (acc.idx == IDX_W'(FLAG_N - 1)) begin
						st_q <= C_IDLE;
					end else begin
						acc.idx <= acc.idx + IDX_W'(1);
					end
				end
			end
			default: begin
				st_q <= C_IDLE;
			end
			endcase
		end
	end

	// status and the map of tokens this port believes it holds
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			busy_q      <= 1'b0;
			done_q      <= 1'b0;
			grant_q     <= 1'b0;
			last_byte_q <= '0;
			owned_q     <= '0;
		end else begin
			if (go_q) begin
				busy_q  <= 1'b1;
				done_q  <= 1'b0;
				grant_q <= 1'b0;
			end else if (st_q != C_IDLE && st_q != C_REL_WR &&
				st_q != C_INIT_WR && acc.done) begin
				last_byte_q <= acc.rdata;
			end
			if (st_q == C_IDLE && busy_q && !go_q) begin
				busy_q <= 1'b0;
				done_q <= 1'b1;
			end
			if (acc.done && (st_q == C_ACQ_RD || st_q == C_READ)) begin
				grant_q <= (flag_rd == FLAG_TAKEN);
				if (flag_rd == FLAG_TAKEN) begin
					owned_q[acc.idx] <= 1'b1;
				end
			end
			if (acc.done && (st_q == C_REL_WR || st_q == C_INIT_WR)) begin
				owned_q[acc.idx] <= 1'b0;
			end
		end
	end

endmodule // sps_host
`default_nettype wire

// File: tb/sps_host_properties.sv
`timescale 1ns/1ps
`default_nettype none
module sps_host_properties
	import sps_pkg::*;
#(
	parameter int STEP = STEP_CYC
) (
	input wire logic              clk_sys,
	input wire logic              nrst,
	input wire logic              ce_n,
	input wire logic              semaphore_select_n,
	input wire logic              oe_n,
	input wire logic              rw_n,
	input wire logic [IDX_W-1:0]  flag_index_lines,
	input wire logic [DATA_W-1:0] io_out,
	input wire logic              io_oe_n
);
	// cycles the current strobe has been low; one counter serves both strobes
	logic [7:0] low_q;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			low_q <= 8'h00;
		else if (!oe_n || !rw_n)
			low_q <= low_q + 8'h01;
		else
			low_q <= 8'h00;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	chk_ce_parked: assert property (ce_n)
		else $error("memory chip enable went active");
	chk_read_space: assert property (
		!oe_n |-> !semaphore_select_n && io_oe_n)
		else $error("read strobe outside semaphore select");
	chk_write_space: assert property (
		!rw_n |-> !semaphore_select_n && !io_oe_n && oe_n)
		else $error("write strobe outside semaphore select");
	chk_data_spread: assert property (
		!io_oe_n |-> io_out == {DATA_W{io_out[0]}})
		else $error("write byte not one repeated bit");
	chk_write_hold: assert property (
		!rw_n |-> $stable(io_out) && $stable(flag_index_lines))
		else $error("write data or index moved under strobe");
	chk_index_hold: assert property (
		!semaphore_select_n && !$past(semaphore_select_n)
		|-> $stable(flag_index_lines))
		else $error("index moved while selected");
	chk_write_width: assert property (
		$rose(rw_n) |-> low_q == 2*STEP)
		else $error("write strobe width wrong");
	chk_read_width: assert property (
		$rose(oe_n) |-> low_q == 2*STEP)
		else $error("read strobe width wrong");
	chk_poll_reselect: assert property (
		$rose(oe_n) |-> ##[1:20] $rose(semaphore_select_n))
		else $error("select not dropped after read");
endmodule // sps_host_properties
bind sps_host sps_host_properties #(.STEP(STEP)) u_sps_host_properties (
	.clk_sys(clk_sys),
	.nrst(nrst),
	.ce_n(ce_n),
	.semaphore_select_n(semaphore_select_n),
	.oe_n(oe_n),
	.rw_n(rw_n),
	.flag_index_lines(flag_index_lines),
	.io_out(io_out),
	.io_oe_n(io_oe_n)
);
`default_nettype wire

// File: tb/sps_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module sps_dev_model (
	input  wire logic       ce_n,
	input  wire logic       sel_n,
	input  wire logic       oe_n,
	input  wire logic       rw_n,
	input  wire logic [2:0] idx,
	input  wire logic [7:0] io_out,
	input  wire logic       io_oe_n,
	output var  logic [7:0] io_in,
	input  wire logic       r_sel_n,
	input  wire logic       r_oe_n,
	input  wire logic       r_rw_n,
	input  wire logic [2:0] r_idx,
	input  wire logic       r_d0,
	output var  logic [7:0] r_q
);
	// eight token latches, no array behind them
	logic [7:0] req_l, req_r, own_l, own_r;
	logic       lq, rq;
	wire        l_rd = ce_n && !sel_n && !oe_n;
	wire        r_rd = !r_sel_n && !r_oe_n;
	// power-up garbage: right holds every token, left has requests pending
	initial begin
		req_l = 8'h00;
		req_r = 8'h00;
		own_l = 8'h00;
		own_r = 8'hff;
		lq = 1'b0;
		rq = 1'b0;
	end
	// writer earlier in time wins; an owner's release hands over
	task automatic put(input bit side, input int i, input logic v);
		if (side)
			req_r[i] = v;
		else
			req_l[i] = v;
		if (own_l[i] && req_l[i])
			own_l[i] = 1'b0;
		if (own_r[i] && req_r[i])
			own_r[i] = 1'b0;
		if (!(own_l[i] || own_r[i])) begin
			if (!req_l[i] && (!side || req_r[i]))
				own_l[i] = 1'b1;
			else if (!req_r[i])
				own_r[i] = 1'b1;
		end
	endtask
	// only data bit zero counts, only three index lines
	always @(posedge rw_n)
		if (!sel_n && ce_n && !io_oe_n)
			put(1'b0, idx, io_out[0]);
	always @(posedge r_rw_n)
		if (!r_sel_n)
			put(1'b1, r_idx, r_d0);
	// captured once per select/oe pair, flag spread on every bit
	always @(posedge l_rd)
		lq = !own_l[idx];
	always @(posedge r_rd)
		rq = !own_r[r_idx];
	// released bus shows the inverse of the last value, no pull-up
	assign io_in = l_rd ? {8{lq}} : {8{~lq}};
	assign r_q = r_rd ? {8{rq}} : {8{~rq}};
endmodule // sps_dev_model
`default_nettype wire

// File: tb/sps_host_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sps_host_tb;
	import sps_pkg::*;
	logic              clk_sys, nrst;
	logic [AXI_AW-1:0] awaddr, araddr;
	logic [31:0]       wdata, rdata, sts;
	logic [1:0]        bresp, rresp, rsp;
	logic              awvalid, awready, wvalid, wready, bvalid, bready;
	logic              arvalid, arready, rvalid, rready;
	logic              ce_n, sel_n, oe_n, rw_n, io_oe_n;
	logic [IDX_W-1:0]  idx, r_idx;
	logic [DATA_W-1:0] io_out, io_in, r_q, q;
	logic              r_sel_n, r_oe_n, r_rw_n, r_d0;
	int                err_count, tests_run;

	sps_host #(.STEP(3)) u_sps_host (
		.clk_sys(clk_sys), .nrst(nrst),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .ce_n(ce_n),
		.semaphore_select_n(sel_n), .oe_n(oe_n), .rw_n(rw_n),
		.flag_index_lines(idx), .io_out(io_out), .io_oe_n(io_oe_n),
		.io_in(io_in));
	sps_dev_model u_sps_dev_model (
		.ce_n(ce_n), .sel_n(sel_n), .oe_n(oe_n), .rw_n(rw_n), .idx(idx),
		.io_out(io_out), .io_oe_n(io_oe_n), .io_in(io_in),
		.r_sel_n(r_sel_n), .r_oe_n(r_oe_n), .r_rw_n(r_rw_n),
		.r_idx(r_idx), .r_d0(r_d0), .r_q(r_q));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		rsp = bresp;
		bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask
	task automatic go(input sps_op_t op, input logic [2:0] i, input logic rt);
		logic [31:0] w;
		w = 32'h0;
		w[CMD_IDX_LSB +: IDX_W] = i;
		w[CMD_OP_LSB +: 2] = op;
		w[CMD_RETRY_BIT] = rt;
		axi_wr(REG_CMD, w);
	endtask
	task automatic wait_done();
		do axi_rd(REG_STATUS, sts);
		while (sts[STS_BUSY_BIT] !== 1'b0 || sts[STS_DONE_BIT] !== 1'b1);
	endtask
	task automatic cmd(input sps_op_t op, input logic [2:0] i);
		go(op, i, 1'b0);
		wait_done();
	endtask
	// right-hand processor, same write-strobe shape as a plain sram
	task automatic r_wr(input logic [2:0] i, input logic v);
		@(posedge clk_sys);
		r_idx <= i;
		r_d0 <= v;
		r_sel_n <= 1'b0;
		@(posedge clk_sys);
		r_rw_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		r_rw_n <= 1'b1;
		@(posedge clk_sys);
		r_sel_n <= 1'b1;
	endtask
	task automatic r_rd(input logic [2:0] i, output logic [7:0] v);
		@(posedge clk_sys);
		r_idx <= i;
		r_sel_n <= 1'b0;
		r_oe_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		v = r_q;
		r_oe_n <= 1'b1;
		r_sel_n <= 1'b1;
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (40000) @(posedge clk_sys);
		err_count++;
		tally_and_finish();
	end
	initial begin
		{nrst, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
		{awaddr, araddr, wdata} = '0;
		{r_sel_n, r_oe_n, r_rw_n, r_d0, r_idx} = 7'h78;
		err_count = 0;
		tests_run = 0;
		repeat (8) @(posedge clk_sys);
		chk({ce_n, sel_n, oe_n, rw_n, io_oe_n}, 32'h1f);
		nrst <= 1'b1;
		cmd(OP_INIT, 3'd0);
		for (int i = 0; i < FLAG_N; i++) r_wr(i[2:0], 1'b1);
		axi_rd(REG_OWNED, sts);
		chk(sts, 32'h0);
		chk(rsp, RESP_OKAY);
		for (int i = 0; i < FLAG_N; i++) begin
			r_rd(i[2:0], q);
			chk(q, 8'hff);
		end
		cmd(OP_ACQUIRE, 3'd5);
		chk(sts[STS_GRANT_BIT], 1'b1);
		chk(sts[STS_IDX_LSB +: IDX_W], 3'd5);
		axi_rd(REG_OWNED, sts);
		chk(sts, 32'h20);
		axi_rd(REG_CMD, sts);
		chk(sts, 32'h15);
		r_rd(3'd5, q);
		chk(q, 8'hff);
		r_rd(3'd4, q);
		chk(q, 8'hff);
		r_wr(3'd5, 1'b0);
		r_rd(3'd5, q);
		chk(q, 8'hff);
		cmd(OP_READ, 3'd5);
		chk(sts[STS_BYTE_LSB +: 8], 8'h00);
		cmd(OP_RELEASE, 3'd5);
		r_rd(3'd5, q);
		chk(q, 8'h00);
		cmd(OP_ACQUIRE, 3'd5);
		chk(sts[STS_GRANT_BIT], 1'b0);
		go(OP_ACQUIRE, 3'd5, 1'b1);
		chk(rsp, RESP_OKAY);
		// let the first read back fail so the retry loop really polls
		repeat (40) @(posedge clk_sys);
		r_wr(3'd5, 1'b1);
		wait_done();
		chk(sts[STS_GRANT_BIT], 1'b1);
		cmd(OP_RELEASE, 3'd5);
		r_rd(3'd5, q);
		chk(q, 8'hff);
		// cancelled retry must leave no request behind to grab the token
		r_wr(3'd3, 1'b0);
		go(OP_ACQUIRE, 3'd3, 1'b1);
		axi_wr(REG_CMD, 32'h200);
		wait_done();
		chk(sts[STS_GRANT_BIT], 1'b0);
		// the cancel write arrived while busy, so it started nothing
		axi_rd(REG_CMD, sts);
		chk(sts, 32'h113);
		r_wr(3'd3, 1'b1);
		cmd(OP_READ, 3'd3);
		chk(sts[STS_BYTE_LSB +: 8], 8'hff);
		fork
			cmd(OP_ACQUIRE, 3'd1);
			r_wr(3'd1, 1'b0);
		join
		r_rd(3'd1, q);
		chk(sts[STS_GRANT_BIT] ^ (q === 8'h00), 1'b1);
		axi_wr(8'h40, 32'h0);
		chk(rsp, RESP_SLVERR);
		axi_rd(8'h40, sts);
		chk(rsp, RESP_SLVERR);
		chk(sts, 32'h0);
		tally_and_finish();
	end
endmodule // sps_host_tb
`default_nettype wire
